// >>> hdl/sura_pkg.sv
// Package with the constants of the shared divisor-high / frame configuration access block.
package sura_pkg;
  localparam int unsigned SURA_DATA_W    = 8;
  localparam int unsigned SURA_SEL_BIT   = 7;
  localparam logic [7:0]  SURA_DIVH_RST  = 8'h00;
  localparam logic [7:0]  SURA_CFG_RST   = 8'h06;
  localparam logic [3:0]  SURA_DIVH_MASK = 4'hf;
  localparam logic        SURA_FLAG_RST  = 1'b0;
endpackage

// >>> hdl/sura_reg8.sv
// Eight-bit storage register with load strobe.
`timescale 1ns/100ps
module sura_reg8
  import sura_pkg::*;
#(
  parameter logic [7:0] RST_VAL = 8'h00
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic [7:0] din,
  output logic      [7:0] q
);
  logic [7:0] next_q;

  always_comb
  begin
    next_q = q;
    if (load)
    begin
      next_q = din;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q <= RST_VAL;
    end
    else
    begin
      q <= next_q;
    end
  end
endmodule

// >>> hdl/sura_top.sv
// Access logic for the I/O address shared by the baud divisor high and frame configuration registers.
//
// Function
// - A write with the select bit clear loads the divisor high register only.
// - A write with the select bit set loads the frame configuration register only.
// - A read not preceded by a read of this address one cycle earlier returns the divisor high register.
// - A read that directly follows a read of this address returns the frame configuration register.
`timescale 1ns/100ps
module sura_top
  import sura_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       sel,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  output logic      [7:0] baud_divisor_high,
  output logic      [7:0] frame_cfg
);
  // ********************************************************
  // Local constants
  // ********************************************************
  localparam logic [7:0] SEL_MASK    = 8'h01 << SURA_SEL_BIT;
  localparam logic [7:0] CFG_RST_VAL = SURA_CFG_RST | SEL_MASK;
  localparam logic [7:0] DIVH_KEEP   = 8'(SURA_DIVH_MASK);
  localparam logic [7:0] RDATA_RST   = 8'h00;

  // ********************************************************
  // Write decode
  // ********************************************************
  logic       wr_access;
  logic       register_select_bit;
  logic       load_divh;
  logic       load_cfg;
  logic [7:0] divh_din;
  logic [7:0] divh_q;

  assign wr_access           = sel & wr_en;
  assign register_select_bit = wdata[SURA_SEL_BIT];
  assign load_divh           = wr_access & ~register_select_bit;
  assign load_cfg            = wr_access & register_select_bit;
  // Only the low nibble of the divisor high part exists; the top bits read as zero.
  assign divh_din            = wdata & DIVH_KEEP;
  assign baud_divisor_high   = divh_q;

  sura_reg8 #(
    .RST_VAL (SURA_DIVH_RST)
  ) u_divh (
    .clk   (clk),
    .rst_n (rst_n),
    .load  (load_divh),
    .din   (divh_din),
    .q     (divh_q)
  );

  // The select bit is kept set in the stored configuration so a read shows it as one.
  sura_reg8 #(
    .RST_VAL (CFG_RST_VAL)
  ) u_cfg (
    .clk   (clk),
    .rst_n (rst_n),
    .load  (load_cfg),
    .din   (wdata),
    .q     (frame_cfg)
  );

  // ********************************************************
  // Read sequence
  // ********************************************************
  // A read arms the sequence for exactly one cycle; any other cycle, a lone write included, disarms it.
  typedef enum logic
  {
    SURA_RD_IDLE,
    SURA_RD_ARMED
  } sura_rd_state_t;

  logic           rd_access;
  logic           rd_prev;
  logic [7:0]     next_rdata;
  sura_rd_state_t rd_state;
  sura_rd_state_t next_rd_state;

  assign rd_access = sel & rd_en;
  assign rd_prev   = (rd_state == SURA_RD_ARMED);

  always_comb
  begin
    next_rd_state = rd_state;
    next_rdata    = rdata;
    case (rd_state)
      SURA_RD_IDLE:
      begin
        if (rd_access)
        begin
          next_rd_state = SURA_RD_ARMED;
          next_rdata    = divh_q;
        end
      end
      SURA_RD_ARMED:
      begin
        next_rd_state = SURA_RD_IDLE;
        if (rd_access)
        begin
          next_rd_state = SURA_RD_ARMED;
          next_rdata    = frame_cfg;
        end
      end
      default:
      begin
        next_rd_state = SURA_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_state <= SURA_RD_IDLE;
      rdata    <= RDATA_RST;
    end
    else
    begin
      rd_state <= next_rd_state;
      rdata    <= next_rdata;
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  a_flag_tracks_read: assert property (@(posedge clk) disable iff (!rst_n)
    rd_prev == ($past(rd_access) && $past(rst_n)))
    else $error("read flag does not follow previous read");

  a_single_read_divh: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_access && !rd_prev) |=> (rdata == $past(divh_q)))
    else $error("single read did not return divisor high");

  a_double_read_cfg: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_access && rd_prev) |=> (rdata == $past(frame_cfg)))
    else $error("second read did not return configuration");

  a_back_to_back: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_access ##1 rd_access) |=> (rdata == $past(frame_cfg)))
    else $error("back to back reads did not yield configuration");

  a_write_divh: assert property (@(posedge clk) disable iff (!rst_n)
    load_divh |=> (divh_q == ($past(wdata) & DIVH_KEEP)) && $stable(frame_cfg))
    else $error("divisor high write wrong");

  a_write_cfg: assert property (@(posedge clk) disable iff (!rst_n)
    load_cfg |=> (frame_cfg == $past(wdata)) && $stable(divh_q))
    else $error("configuration write wrong");

  a_idle_holds: assert property (@(posedge clk) disable iff (!rst_n)
    !rd_access |=> !rd_prev && $stable(rdata))
    else $error("idle cycle changed read state");

  a_no_write_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_access |=> $stable(divh_q) && $stable(frame_cfg))
    else $error("register changed without write");

  a_write_exclusive: assert property (@(posedge clk) disable iff (!rst_n)
    !(load_divh && load_cfg))
    else $error("one write selected both registers");

  a_divh_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (baud_divisor_high & ~DIVH_KEEP) == '0)
    else $error("divisor high upper bits not zero");

  a_cfg_sel_set: assert property (@(posedge clk) disable iff (!rst_n)
    frame_cfg[SURA_SEL_BIT])
    else $error("configuration select bit not set");

  a_flag_set_read: assert property (@(posedge clk) disable iff (!rst_n)
    rd_access |=> rd_prev)
    else $error("read did not set the read flag");

  a_flag_from_read: assert property (@(posedge clk) disable iff (!rst_n)
    rd_prev |-> $past(rd_access))
    else $error("read flag set without a read");

  a_gap_restarts: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_access ##1 !rd_access ##1 rd_access) |=> (rdata == $past(divh_q)))
    else $error("read after a gap did not return divisor high");

  a_write_gap_divh: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_access ##1 (wr_access && !rd_access) ##1 rd_access) |=> (rdata == $past(divh_q)))
    else $error("read after a write did not return divisor high");

  a_third_read_cfg: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_access ##1 rd_access ##1 rd_access) |=> (rdata == $past(frame_cfg)))
    else $error("third read in a row did not return configuration");

  a_read_during_write: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_access && wr_access) |=> (rdata == $past(rd_prev ? frame_cfg : divh_q)))
    else $error("read during write did not return the old value");

  a_rdata_on_read: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(rst_n) && $changed(rdata)) |-> $past(rd_access))
    else $error("read data changed without a read");

  a_divh_on_write: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(rst_n) && $changed(divh_q)) |-> $past(load_divh))
    else $error("divisor high changed without its write");

  a_cfg_on_write: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(rst_n) && $changed(frame_cfg)) |-> $past(load_cfg))
    else $error("configuration changed without its write");

  a_reset_state: assert property (@(posedge clk) !rst_n |=>
    (rd_prev == SURA_FLAG_RST) && (rdata == RDATA_RST) &&
    (divh_q == SURA_DIVH_RST) && (frame_cfg == CFG_RST_VAL))
    else $error("reset did not restore the access state");
endmodule

// >>> tb/test_sura_top.sv
// Self-checking testbench for the shared divisor-high / frame configuration access block.
`timescale 1ns/100ps
module test_sura_top
  import sura_pkg::*;
;
  logic       clk = 0, rst_n = 0, sel = 0, wr_en = 0, rd_en = 0, m_prev = 0, pend = 0;
  logic [7:0] wdata = 8'h00, rdata, divh, cfg, m_divh = SURA_DIVH_RST, m_cfg = 8'h86;
  logic [7:0] expq[$];
  int         n_mismatch = 0, tests_run = 0;

  always #2 clk = ~clk;

  sura_top u_sura_top (.clk(clk), .rst_n(rst_n), .sel(sel), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata),
                       .rdata(rdata), .baud_divisor_high(divh), .frame_cfg(cfg));

  task chk(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task test_done;
    $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Drives one cycle of access and notes the expected read data and register contents.
  task op(logic s, logic w, logic r, logic [7:0] d);
    sel = s;
    wr_en = w;
    rd_en = r;
    wdata = d;
    if (s && r) expq.push_back(m_prev ? m_cfg : m_divh);
    if (s && w && d[SURA_SEL_BIT]) m_cfg = d;
    if (s && w && !d[SURA_SEL_BIT]) m_divh = {4'h0, d[3:0]};
    m_prev = s && r;
    @(negedge clk);
    chk("divisor_high", m_divh, divh);
    chk("frame_cfg", m_cfg, cfg);
  endtask

  // Read data shows one cycle after the read is taken.
  always @(posedge clk) pend <= sel && rd_en;
  always @(negedge clk) if (pend) chk("rdata", expq.pop_front(), rdata);

  initial
  begin
    void'($urandom(10172));
    repeat (3) @(negedge clk);
    chk("rst_divisor_high", SURA_DIVH_RST, divh);
    chk("rst_frame_cfg", 8'h86, cfg);
    chk("rst_rdata", 8'h00, rdata);
    rst_n = 1;
    op(1, 1, 0, 8'h72);
    op(1, 1, 0, 8'ha5);
    op(1, 0, 1, 8'h00);
    op(0, 0, 0, 8'h00);
    op(1, 0, 1, 8'h00);
    op(1, 1, 1, 8'h05);
    op(1, 0, 1, 8'h00);
    op(1, 1, 0, 8'h83);
    op(1, 0, 1, 8'h00);
    repeat (300) op(1'($urandom), 1'($urandom), 1'($urandom), 8'($urandom));
    op(0, 0, 0, 8'h00);
    // A second reset in mid-run must restore the registers and disarm the read sequence.
    rst_n = 0;
    repeat (2) @(negedge clk);
    m_divh = SURA_DIVH_RST;
    m_cfg = 8'h86;
    m_prev = 0;
    chk("rst2_divisor_high", m_divh, divh);
    chk("rst2_frame_cfg", m_cfg, cfg);
    chk("rst2_rdata", 8'h00, rdata);
    rst_n = 1;
    op(1, 0, 1, 8'h00);
    op(1, 0, 1, 8'h00);
    op(0, 0, 0, 8'h00);
    @(negedge clk);
    test_done;
  end

  initial
  begin
    // The tests need about 320 cycles of 4 ns; this limit leaves a wide margin.
    #10000;
    n_mismatch++;
    test_done;
  end
endmodule
